//--- rtl/dma_ctrl_pkg.sv
/*
 * Shared constants and carrier types for the DMA global control and
 * request-line pacing block.
 * Assumes a 32-bit classic Wishbone register port and one system clock.
 */
package dma_ctrl_pkg;
	localparam int unsigned NUM_CH         = 16;
	localparam int unsigned NUM_EN         = 15;
	localparam int unsigned NUM_REQ        = 32;
	localparam int unsigned SEL_W          = 5;
	localparam int unsigned BEAT_W         = 5;
	localparam logic [7:0]  OFS_ENABLE     = 8'h00;
	localparam logic [7:0]  OFS_REQSEL_0   = 8'h40;
	localparam logic [7:0]  OFS_ARB        = 8'h80;
	localparam int unsigned LITE_POS       = 28;
	localparam int unsigned PAGE_POS       = 24;
	localparam int unsigned PAGE_SHIFT     = 30;
	localparam logic [14:0] EN_RESET       = 15'h7FFF;
	localparam logic [3:0]  PAGE_RESET     = 4'h0;
	localparam logic [1:0]  UNCACHED_TOP   = 2'h3;
	localparam int unsigned LITE_FIRST     = 7;
	localparam int unsigned LITE_LAST      = 10;
	localparam int unsigned WIDE_LAST      = 6;
	localparam int unsigned SHARED_FIRST   = 24;
	localparam int unsigned SHARED_LAST    = 26;
	localparam logic [4:0]  MAX_BURST      = 5'h10;
	localparam logic [4:0]  NARROW_BUF     = 5'h08;
	localparam logic [4:0]  FIFO_NARROW    = 5'h10;
	localparam logic [4:0]  FIFO_WIDE      = 5'h09;
	localparam logic [4:0]  WIDE_BUF       = 5'h02;
	localparam int unsigned RS_READ        = 0;
	localparam int unsigned RS_WRITE       = 1;
	localparam int unsigned RS_WAITR       = 2;
	localparam int unsigned RS_IGNORE      = 3;
	localparam int unsigned RS_SEL         = 8;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        wide;
		logic [4:0]  beats;
	} burst_req_s;

	typedef struct packed {
		logic [4:0]  line;
		logic        pace_rd;
		logic        pace_wr;
		logic        wait_write_response;
		logic        discard_destination;
	} chan_cfg_s;
endpackage : dma_ctrl_pkg

//--- rtl/data_request_line_sync.sv
/*
 * Two-flop synchroniser bank for the data-request lines.
 * Assumes request lines may change at any time relative to clock.
 */
`timescale 1ns/1ps
module data_request_line_sync #(
	parameter int unsigned WIDTH = 32
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;
	sync_s st_r;
	sync_s st_nxt;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.meta   = async_in;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;
endmodule : data_request_line_sync

//--- rtl/chan_pacer.sv
/*
 * Per-channel pacing engine: gates read and write bursts on the selected
 * request line, limits burst sizes and throttles reads by buffer room.
 * Assumes the engine holds burst_req until burst_go and reports done.
 */
`timescale 1ns/1ps
module chan_pacer #(
	parameter bit HAS_FIFO = 1'b0
) (
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	input  wire logic                     chan_on,
	input  wire dma_ctrl_pkg::chan_cfg_s  cfg,
	input  wire logic                     line_level,
	input  wire dma_ctrl_pkg::burst_req_s burst_req,
	input  wire logic                     read_done,
	input  wire logic                     write_resp,
	input  wire logic [4:0]               buf_room,
	output logic                          burst_go,
	output logic [4:0]                    burst_beats,
	output logic                          read_stall,
	output logic                          busy
);
	typedef enum logic [1:0] {IDLE, RD_WAIT, WR_WAIT} pstate_e;
	typedef struct packed {
		pstate_e    state;
		logic [4:0] beats;
		logic       go;
	} pace_s;
	pace_s st_r;
	pace_s st_nxt;
	logic [4:0] limit;
	logic       gate_ok;
	logic       room_ok;

	always_comb begin
		limit = dma_ctrl_pkg::MAX_BURST;
		if (!burst_req.write && !cfg.discard_destination) begin
			if (HAS_FIFO) begin
				limit = burst_req.wide ? dma_ctrl_pkg::FIFO_WIDE
					: dma_ctrl_pkg::FIFO_NARROW;
			end else begin
				limit = burst_req.wide ? dma_ctrl_pkg::WIDE_BUF
					: dma_ctrl_pkg::NARROW_BUF;
			end
		end
	end

	assign gate_ok = burst_req.write ? (!cfg.pace_wr || line_level)
		: (!cfg.pace_rd || line_level);
	assign room_ok = burst_req.write || cfg.discard_destination
		|| (buf_room != 5'h00);

	always_comb begin
		st_nxt    = st_r;
		st_nxt.go = 1'b0;
		unique case (st_r.state)
			IDLE: begin
				if (chan_on && burst_req.valid && gate_ok && room_ok
					&& !st_r.go) begin
					st_nxt.go    = 1'b1;
					st_nxt.beats = (burst_req.beats > limit) ? limit
						: burst_req.beats;
					if (burst_req.write) begin
						if (cfg.wait_write_response) begin
							st_nxt.state = WR_WAIT;
						end
					end else begin
						st_nxt.state = RD_WAIT;
					end
				end
			end
			RD_WAIT: begin
				if (read_done) begin
					st_nxt.state = IDLE;
				end
			end
			WR_WAIT: begin
				if (write_resp) begin
					st_nxt.state = IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{state: IDLE, beats: 5'h00, go: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign burst_go    = st_r.go;
	assign burst_beats = st_r.beats;
	assign read_stall  = (st_r.state == RD_WAIT)
		&& (buf_room == 5'h00) && !cfg.discard_destination;
	assign busy        = (st_r.state != IDLE) || st_r.go;

	chk_read_regate: assert property (@(posedge clock) disable iff (!reset_n)
		(st_r.state == RD_WAIT && !read_done) |=> !st_r.go)
		else $error("read launched before data returned");
	chk_write_single: assert property (@(posedge clock) disable iff (!reset_n)
		(st_r.state == WR_WAIT && !write_resp) |=> !st_r.go)
		else $error("second write issued before response");
	chk_burst_cap: assert property (@(posedge clock) disable iff (!reset_n)
		st_r.go |-> st_r.beats <= dma_ctrl_pkg::MAX_BURST)
		else $error("burst over sixteen beats");
	chk_pace_gate: assert property (@(posedge clock) disable iff (!reset_n)
		st_r.go && !$past(burst_req.write) && $past(cfg.pace_rd)
		|-> $past(line_level))
		else $error("paced read without request");
endmodule : chan_pacer

//--- rtl/dma_global_ctrl.sv
/*
 * Global control of the multi-channel DMA: channel enables, SDRAM page
 * remapping, request-line selection and pacing of every channel.
 * Assumes classic Wishbone register access and per-channel engines that
 * present burst requests and report read completion and write responses.
 */
// Chosen here: the placing of the registers and the Wishbone slave port.
// Operation
// - Lite channels remap uncached range by lite page
// - Wide channels remap uncached range by page
// - Per-channel enable bits, reset to one; code has bits for channels 0-14 only, channel 15 is always on
// - Each channel selects line and paced direction
// - Request line zero is always active
// - Paced read waits for line, then data
// - Never read without buffer room; code lets discard_destination reads issue with zero buf_room
// - Wait-response allows one outstanding write
// - Thirty-two fixed request lines
// - Lines 24-26 secondary source removable
// - Bursts never exceed sixteen beats
// - Narrow peripheral read bursts limited eight
// - Discard-destination allows sixteen beat reads
// - Channels 0, 15 fifo extends read bursts
// - Oversized read burst stalls the read bus; code clamps bursts to the limit, read_stall marks zero buf_room
`timescale 1ns/1ps
module dma_global_ctrl (
	input  wire logic                                 clock,
	input  wire logic                                 reset_n,
	input  wire logic                                 wb_cyc_i,
	input  wire logic                                 wb_stb_i,
	input  wire logic                                 wb_we_i,
	input  wire logic [7:0]                           wb_adr_i,
	input  wire logic [3:0]                           wb_sel_i,
	input  wire logic [31:0]                          wb_dat_i,
	output logic      [31:0]                          wb_dat_o,
	output logic                                      wb_ack_o,
	input  wire logic [31:0]                          periph_req,
	input  wire logic [2:0]                           secondary_req,
	input  wire logic [15:0][31:0]                    chan_addr,
	output logic      [15:0][34:0]                    sdram_addr,
	input  wire dma_ctrl_pkg::burst_req_s [15:0]      burst_req,
	input  wire logic [15:0]                          read_done,
	input  wire logic [15:0]                          write_resp,
	input  wire logic [15:0][4:0]                     buf_room,
	output logic      [15:0]                          burst_go,
	output logic      [15:0][4:0]                     burst_beats,
	output logic      [15:0]                          read_stall,
	output logic      [15:0]                          chan_busy,
	output logic      [14:0]                          chan_on
);
	localparam int unsigned NCH = dma_ctrl_pkg::NUM_CH;

	typedef struct packed {
		logic [3:0]                 lite_page;
		logic [3:0]                 page;
		logic [14:0]                enables;
		logic                       secondary_source_off;
		logic [NCH-1:0][8:0]        reqsel;
		logic                       ack;
		logic [31:0]                rdata;
	} regs_s;
	regs_s st_r;
	regs_s st_nxt;

	logic [31:0] req_sync;
	logic [2:0]  sec_sync;
	logic [31:0] line_vec;
	logic        wb_hit;
	logic [31:0] rd_word;

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	function automatic logic [34:0] remap(input logic [31:0] a,
		input logic [3:0] pg);
		logic [34:0] r;
		r = {3'h0, a};
		if (a[31:30] == dma_ctrl_pkg::UNCACHED_TOP) begin
			r = {1'b0, pg, a[29:0]};
		end
		return r;
	endfunction : remap

	////////////////////////////////////////////////////////////////////////
	// Request line conditioning

	data_request_line_sync #(
		.WIDTH(32)
	) u_sync_main (
		.clock   (clock),
		.reset_n (reset_n),
		.async_in(periph_req),
		.sync_out(req_sync)
	);

	data_request_line_sync #(
		.WIDTH(3)
	) u_sync_sec (
		.clock   (clock),
		.reset_n (reset_n),
		.async_in(secondary_req),
		.sync_out(sec_sync)
	);

	always_comb begin
		line_vec    = req_sync;
		line_vec[0] = 1'b1;
		for (int i = dma_ctrl_pkg::SHARED_FIRST;
			i <= dma_ctrl_pkg::SHARED_LAST; i++) begin
			line_vec[i] = req_sync[i] | (sec_sync[i-24]
				& ~st_r.secondary_source_off);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	assign wb_hit = wb_cyc_i && wb_stb_i && !st_r.ack;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (wb_adr_i == dma_ctrl_pkg::OFS_ENABLE) begin
			rd_word = {st_r.lite_page, st_r.page, 9'h000,
				st_r.enables};
		end else if (wb_adr_i == dma_ctrl_pkg::OFS_ARB) begin
			rd_word = {31'h0000_0000, st_r.secondary_source_off};
		end else if (wb_adr_i >= dma_ctrl_pkg::OFS_REQSEL_0
			&& wb_adr_i < dma_ctrl_pkg::OFS_ARB
			&& wb_adr_i[1:0] == 2'h0) begin
			rd_word = {23'h00_0000, st_r.reqsel[wb_adr_i[5:2]]};
		end
	end

	always_comb begin
		logic [31:0] m;
		m      = 32'h0000_0000;
		st_nxt = st_r;
		st_nxt.ack = wb_hit;
		if (wb_hit) begin
			st_nxt.rdata = rd_word;
			if (wb_we_i) begin
				m = lane_merge(rd_word, wb_dat_i, wb_sel_i);
				if (wb_adr_i == dma_ctrl_pkg::OFS_ENABLE) begin
					st_nxt.lite_page = m[31:28];
					st_nxt.page      = m[27:24];
					st_nxt.enables   = m[14:0];
				end else if (wb_adr_i == dma_ctrl_pkg::OFS_ARB) begin
					st_nxt.secondary_source_off = m[0];
				end else if (wb_adr_i >= dma_ctrl_pkg::OFS_REQSEL_0
					&& wb_adr_i < dma_ctrl_pkg::OFS_ARB
					&& wb_adr_i[1:0] == 2'h0) begin
					st_nxt.reqsel[wb_adr_i[5:2]] = m[8:0];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{lite_page: dma_ctrl_pkg::PAGE_RESET,
				page: dma_ctrl_pkg::PAGE_RESET,
				enables: dma_ctrl_pkg::EN_RESET,
				secondary_source_off: 1'b0,
				reqsel: '0, ack: 1'b0, rdata: 32'h0000_0000};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;
	assign chan_on  = st_r.enables;

	////////////////////////////////////////////////////////////////////////
	// Channel address remap and pacing

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			dma_ctrl_pkg::chan_cfg_s cfg;
			logic                    on;
			assign cfg.line                = st_r.reqsel[c][8:4];
			assign cfg.pace_rd             = st_r.reqsel[c][0];
			assign cfg.pace_wr             = st_r.reqsel[c][1];
			assign cfg.wait_write_response = st_r.reqsel[c][2];
			assign cfg.discard_destination = st_r.reqsel[c][3];
			if (c < dma_ctrl_pkg::NUM_EN) begin : g_en
				assign on = st_r.enables[c];
			end else begin : g_noen
				assign on = 1'b1;
			end
			if (c >= dma_ctrl_pkg::LITE_FIRST
				&& c <= dma_ctrl_pkg::LITE_LAST) begin : g_lite
				assign sdram_addr[c] = remap(chan_addr[c],
					st_r.lite_page);
			end else if (c <= dma_ctrl_pkg::WIDE_LAST) begin : g_wide
				assign sdram_addr[c] = remap(chan_addr[c],
					st_r.page);
			end else begin : g_flat
				assign sdram_addr[c] = {3'h0, chan_addr[c]};
			end
			chan_pacer #(
				.HAS_FIFO(c == 0 || c == 15)
			) u_pacer (
				.clock      (clock),
				.reset_n    (reset_n),
				.chan_on    (on),
				.cfg        (cfg),
				.line_level (line_vec[cfg.line]),
				.burst_req  (burst_req[c]),
				.read_done  (read_done[c]),
				.write_resp (write_resp[c]),
				.buf_room   (buf_room[c]),
				.burst_go   (burst_go[c]),
				.burst_beats(burst_beats[c]),
				.read_stall (read_stall[c]),
				.busy       (chan_busy[c])
			);
		end
	endgenerate

	chk_line_zero: assert property (@(posedge clock) disable iff (!reset_n)
		line_vec[0])
		else $error("line zero not active");
	chk_ack_drop: assert property (@(posedge clock) disable iff (!reset_n)
		st_r.ack |=> !st_r.ack)
		else $error("ack held two cycles");
	chk_en_write: assert property (@(posedge clock) disable iff (!reset_n)
		(wb_hit && wb_we_i && wb_adr_i == dma_ctrl_pkg::OFS_ENABLE
		&& wb_sel_i[0]) |=> st_r.enables[7:0] == $past(wb_dat_i[7:0]))
		else $error("enable byte not stored");
	chk_sec_off: assert property (@(posedge clock) disable iff (!reset_n)
		st_r.secondary_source_off |-> line_vec[24] == req_sync[24])
		else $error("secondary source not removed");
endmodule : dma_global_ctrl

//--- testbench/periph_model.sv
/*
 * Peripheral model that drives one data request line.
 * Assumes taken pulses when the channel issues against this line.
 */
`timescale 1ns/1ps
module periph_model (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic ready,
	input  wire logic taken,
	output logic      req
);
////////////////////////////////////////////////////////////////////////////
// Raise only when data or space is ready, drop at once on an issue
always_ff @(posedge clock or negedge reset_n) begin
	if (!reset_n) begin
		req <= 1'b0;
	end else if (taken) begin
		req <= 1'b0;
	end else begin
		req <= ready;
	end
end
endmodule : periph_model

//--- testbench/testbench.sv
/*
 * Self-checking bench for the DMA global control and pacing block.
 * Assumes the design package and a peripheral model on request line 5.
 */
`timescale 1ns/1ps
module testbench;
////////////////////////////////////////////////////////////////////////////
logic                            clock, reset_n, cyc, stb, we;
logic [7:0]                      adr;
logic [3:0]                      sel, pg_m, lite_m;
logic [31:0]                     wdat, rdat, tb_req, periph_req, wb_dat_o;
logic                            wb_ack_o, p_ready, p_req;
logic [2:0]                      sec_req;
logic [15:0][31:0]               caddr;
logic [15:0][34:0]               saddr;
dma_ctrl_pkg::burst_req_s [15:0] breq;
logic [15:0]                     rdone, wresp, go, stall, busy;
logic [15:0][4:0]                room, beats;
logic [14:0]                     chan_on, en_m;
logic [4:0]                      b;
int                              err_total, checks, seed;
int                              tc[6] = '{0, 0, 15, 2, 3, 4};
logic [31:0]                     tv[6] = '{1, 1, 1, 1, 9, 2};
logic                            twd[6] = '{0, 1, 1, 1, 1, 0};
logic [4:0]                      tbt[6] = '{20, 12, 12, 5, 20, 20};

assign periph_req = tb_req | {26'h0, p_req, 5'h0};

dma_global_ctrl dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
	.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
	.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.periph_req(periph_req), .secondary_req(sec_req), .chan_addr(caddr),
	.sdram_addr(saddr), .burst_req(breq), .read_done(rdone),
	.write_resp(wresp), .buf_room(room), .burst_go(go),
	.burst_beats(beats), .read_stall(stall), .chan_busy(busy),
	.chan_on(chan_on));

periph_model pm (.clock(clock), .reset_n(reset_n), .ready(p_ready),
	.taken(go[1]), .req(p_req));

initial begin
	clock = 1'b0;
	forever #10 clock = ~clock;
end
////////////////////////////////////////////////////////////////////////////
task cmp_val(input logic [34:0] got, input logic [34:0] exp, string s);
	checks++;
	if (got !== exp) begin
		err_total++;
		$display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
	end
endtask : cmp_val

task cmp_flag(input logic got, input logic exp, string s);
	cmp_val({34'h0, got}, {34'h0, exp}, s);
endtask : cmp_flag

task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	n = 0;
	@(posedge clock);
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	wdat <= d;
	do begin
		@(posedge clock);
		n++;
	end while (wb_ack_o !== 1'b1 && n < 10);
	cmp_flag(wb_ack_o, 1'b1, "ack");
	rdat = wb_dat_o;
	cyc <= 1'b0;
	stb <= 1'b0;
	if (w && a == 8'h00) begin
		en_m = d[14:0];
		pg_m = d[27:24];
		lite_m = d[31:28];
	end
endtask : wb

function automatic logic [4:0] expb(int ch, logic w, wd, ds, logic [4:0] b);
	int lim;
	lim = (w || ds) ? 16 : (ch == 0 || ch == 15) ? (wd ? 9 : 16) : (wd ? 2 : 8);
	return (b > lim) ? 5'(lim) : b;
endfunction : expb

function automatic logic [34:0] expa(int ch, logic [31:0] a);
	if (a[31:30] != 2'h3 || ch > 10) return {3'h0, a};
	return {1'b0, (ch >= 7) ? lite_m : pg_m, a[29:0]};
endfunction : expa

task burst(input int ch, input logic w, d, input logic [4:0] n, e);
	int k;
	k = 0;
	@(posedge clock);
	breq[ch] <= {1'b1, w, d, n};
	do begin
		@(posedge clock);
		k++;
	end while (go[ch] !== 1'b1 && k < 40);
	cmp_flag(go[ch], 1'b1, "go");
	cmp_val(35'(beats[ch]), 35'(e), "beats");
	breq[ch] <= '0;
endtask : burst

task none(input int ch, input int n);
	int k;
	k = 0;
	repeat (n) begin
		@(negedge clock);
		if (go[ch] !== 1'b0) k++;
	end
	cmp_val(35'(k), 35'h0, "no issue");
	@(posedge clock);
endtask : none

task fin(input int ch);
	@(posedge clock);
	rdone[ch] <= 1'b1;
	wresp[ch] <= 1'b1;
	@(posedge clock);
	rdone[ch] <= 1'b0;
	wresp[ch] <= 1'b0;
endtask : fin

task summarize;
	$display("checks %0d err_total %0d", checks, err_total);
	if (err_total == 0 && checks > 0) begin
		$display("Run complete: PASS");
	end else begin
		$display("Run complete: FAIL");
	end
	$finish;
endtask : summarize
////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (20000) @(posedge clock);
	err_total++;
	summarize();
end

initial begin
	seed = 32'hFA444098;
	{cyc, stb, we, adr, wdat, tb_req, sec_req, p_ready} = '0;
	{rdone, wresp, breq, caddr} = '0;
	sel = 4'hF;
	room = {16{5'h1F}};
	{err_total, checks} = '0;
	{lite_m, pg_m, en_m} = {8'h00, 15'h7FFF};
	reset_n = 1'b0;
	repeat (4) @(posedge clock);
	reset_n <= 1'b1;
	wb(1'b0, 8'h00, 32'h0);
	cmp_val(35'(rdat), 35'({lite_m, pg_m, 9'h0, en_m}), "reset");
	wb(1'b0, 8'h84, 32'h0);
	cmp_val(35'(rdat), 35'h0, "unmapped");
	wb(1'b1, 8'h00, $random(seed) | 32'h00007FFF);
	wb(1'b0, 8'h00, 32'h0);
	cmp_val(35'(rdat), 35'({lite_m, pg_m, 9'h0, en_m}), "reg");
	for (int c = 0; c < 16; c++) begin
		@(posedge clock);
		caddr[c] <= $random(seed) | {c[0], c[0], 30'h0};
		@(negedge clock);
		cmp_val(saddr[c], expa(c, caddr[c]), "remap");
	end
	$display("test registers done");
	wb(1'b1, 8'h44, 32'h00000051);
	@(posedge clock);
	breq[1] <= 8'h8C;
	none(1, 8);
	p_ready <= 1'b1;
	burst(1, 1'b0, 1'b0, 5'h0C, expb(1, 0, 0, 0, 5'h0C));
	breq[1] <= 8'h84;
	room[1] <= 5'h00;
	none(1, 8);
	cmp_flag(stall[1], 1'b1, "stall");
	room[1] <= 5'h1F;
	fin(1);
	burst(1, 1'b0, 1'b0, 5'h04, 5'h04);
	fin(1);
	p_ready <= 1'b0;
	$display("test pacing done");
	for (int i = 0; i < 6; i++) begin
		wb(1'b1, 8'h40 + 8'(4 * tc[i]), tv[i]);
		burst(tc[i], tv[i][1], twd[i], tbt[i],
			expb(tc[i], tv[i][1], twd[i], tv[i][3], tbt[i]));
		fin(tc[i]);
	end
	for (int i = 0; i < 6; i++) begin
		b = 5'($random(seed)) | 5'h01;
		burst(0, 1'b0, 1'b0, b, expb(0, 0, 0, 0, b));
		fin(0);
	end
	$display("test limits done");
	wb(1'b1, 8'h50, 32'h00000006);
	burst(4, 1'b1, 1'b0, 5'h03, 5'h03);
	breq[4] <= 8'hC3;
	none(4, 8);
	cmp_flag(busy[4], 1'b1, "busy");
	fin(4);
	burst(4, 1'b1, 1'b0, 5'h03, 5'h03);
	fin(4);
	wb(1'b1, 8'h00, {lite_m, pg_m, 9'h0, 15'h7FDF});
	cmp_val(35'(chan_on), 35'(en_m), "enables");
	wb(1'b1, 8'h54, 32'h00000001);
	breq[5] <= 8'h82;
	none(5, 8);
	breq[5] <= '0;
	wb(1'b1, 8'h00, {lite_m, pg_m, 9'h0, 15'h7FFF});
	burst(5, 1'b0, 1'b0, 5'h02, 5'h02);
	fin(5);
	wb(1'b1, 8'h58, 32'h00000001);
	room[6] <= 5'h00;
	breq[6] <= 8'h83;
	none(6, 8);
	room[6] <= 5'h04;
	burst(6, 1'b0, 1'b0, 5'h03, 5'h03);
	fin(6);
	wb(1'b1, 8'h5C, 32'h00000181);
	sec_req <= 3'h1;
	burst(7, 1'b0, 1'b0, 5'h02, 5'h02);
	fin(7);
	wb(1'b1, 8'h80, 32'h00000001);
	breq[7] <= 8'h82;
	none(7, 8);
	breq[7] <= '0;
	$display("test gating done");
	summarize();
end
endmodule : testbench
